// >>> hdl/qdsi_pkg.sv
/*
  Shared constants of the quad DAC serial interface: word layout, widths,
  reset values, pin order inside the synchroniser vector and link timing.
  Assumes a 100 MHz system clock on both ends of the link.

// Notes on behaviour
// - Output level equals 2*ref*code/1024, 10-bit code.
// - Power-up clears every latch to zero.
// - Host drives chip select low before transfer.
// - Frame sync falling starts shift, MSB first.
// - Latch word after sixteen bits or frame rise.
// - Chip select lets several devices share port.
// - Single device may hold chip select low.
// - Host without frame sync toggles it by software.
// - Eight-bit hosts send two bytes per frame.
// - Refresh output on rising clock after sixteenth.
// - Bits 15..12 control, 11..0 value field.
// - Code is bits 11..2, bits 1..0 ignored.
// - Bit 12 one fast, zero slow settling.
// - Bit 13 one powers down all amplifiers.
// - Bits 15..14 address channel A to D.
// - Latch-update low pulse updates all outputs together.
// - Power-down pin high keeps converters enabled.
// - Host waits for word end before next.
// - Host pulses frame sync before every word.
*/
package qdsi_pkg;
    localparam int WORD_BITS    = 16;
    localparam int CODE_BITS    = 10;
    localparam int NUM_CH       = 4;
    localparam int CH_BITS      = 2;
    localparam int ENTRY_BITS   = CODE_BITS + 1;
    localparam int ADDR_MSB_POS = 15;
    localparam int ADDR_LSB_POS = 14;
    localparam int PWR_POS      = 13;
    localparam int SPD_POS      = 12;
    localparam int CODE_MSB_POS = 11;
    localparam int CODE_LSB_POS = 2;
    localparam int CNT_BITS     = 5;
    localparam logic [CNT_BITS-1:0] LAST_BIT  = 5'h0F;
    localparam logic [CNT_BITS-1:0] BYTE_LAST = 5'h07;
    localparam logic [CNT_BITS-1:0] CNT_RST   = 5'h00;
    localparam logic [ENTRY_BITS-1:0] ENTRY_RST = 11'h000;
    localparam logic [WORD_BITS-1:0]  WORD_RST  = 16'h0000;
    // Pin order inside the synchroniser vector.
    localparam int PIN_BITS = 6;
    localparam int PIN_SCLK = 5;
    localparam int PIN_FS   = 4;
    localparam int PIN_SDAT = 3;
    localparam int PIN_CSN  = 2;
    localparam int PIN_LDN  = 1;
    localparam int PIN_PDN  = 0;
    // Idle levels: clock low, frame sync high, strobes inactive high.
    localparam logic [PIN_BITS-1:0] PINS_IDLE = 6'h17;
    // Link timing.
    localparam int SYS_CLK_MHZ  = 100;
    localparam int SCLK_HALF_NS = 80;
    localparam int BYTE_GAP_NS  = 160;
    localparam int LATCH_UPDATE_N_LOW_NS  = 80;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int BYTE_GAP_CYC  = (BYTE_GAP_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int LATCH_UPDATE_N_LOW_CYC  = (LATCH_UPDATE_N_LOW_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int TMR_BITS = 8;
    localparam logic [TMR_BITS-1:0] HALF_LOAD = 8'(SCLK_HALF_CYC - 1);
    localparam logic [TMR_BITS-1:0] GAP_LOAD  = 8'(BYTE_GAP_CYC - 1);
    localparam logic [TMR_BITS-1:0] LATCH_UPDATE_N_LOAD = 8'(LATCH_UPDATE_N_LOW_CYC - 1);
    localparam logic [TMR_BITS-1:0] TMR_RST   = 8'h00;
endpackage

// >>> hdl/qdsi_link_if.sv
/*
  Serial link between the host port and the quad DAC: clock, frame sync,
  data, chip select, latch update and hardware power-down.
  Assumes the host drives every wire; the device only listens.
*/
`timescale 1ns/1ps
`default_nettype none
interface qdsi_link_if;
    logic sclk;
    logic frame_sync;
    logic sdata;
    logic cs_n;
    logic latch_update_n;
    logic hw_power_down_n;

    modport dev_mp (
        input sclk,
        input frame_sync,
        input sdata,
        input cs_n,
        input latch_update_n,
        input hw_power_down_n
    );

    modport host_mp (
        output sclk,
        output frame_sync,
        output sdata,
        output cs_n,
        output latch_update_n,
        output hw_power_down_n
    );
endinterface
`default_nettype wire

// >>> hdl/qdsi_dac_end.sv
/*
  Device end of the quad DAC serial link: synchronises the link pins,
  shifts the 16-bit word, decodes it into channel latches and updates
  the channel outputs.
  Assumes every link pin is asynchronous to clk_sys_in and that the link
  clock is slow enough to be seen high and low for at least two cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module qdsi_dac_end (
    input  wire logic                    clk_sys_in,
    input  wire logic                    nrst_in,
    input  wire logic                    ce_in,
    qdsi_link_if.dev_mp                  link,
    output logic [qdsi_pkg::NUM_CH-1:0][qdsi_pkg::CODE_BITS-1:0] dac_code_out,
    output logic [qdsi_pkg::NUM_CH-1:0]  fast_mode_out,
    output logic                         amps_on_out,
    output logic                         busy_out,
    output logic                         word_strobe_out
);

    // Synchroniser stages and the previous synchronised sample.
    logic [qdsi_pkg::PIN_BITS-1:0]   pins_raw;
    logic [qdsi_pkg::PIN_BITS-1:0]   sync1_ff;
    logic [qdsi_pkg::PIN_BITS-1:0]   sync2_ff;
    logic [qdsi_pkg::PIN_BITS-1:0]   prev_ff;

    // Shift engine.
    logic                            active_ff;
    logic [qdsi_pkg::CNT_BITS-1:0]   cnt_ff;
    logic [qdsi_pkg::WORD_BITS-1:0]  shift_ff;
    logic                            pend_ff;
    logic [qdsi_pkg::CH_BITS-1:0]    pend_ch_ff;

    // Channel latches: fast bit above the code.
    logic [qdsi_pkg::NUM_CH-1:0][qdsi_pkg::ENTRY_BITS-1:0] in_ff;
    logic [qdsi_pkg::NUM_CH-1:0][qdsi_pkg::ENTRY_BITS-1:0] out_ff;
    logic                            soft_pd_ff;
    logic                            amps_on_ff;
    logic                            strobe_ff;

    // Decoded pin levels and edges.
    logic                            sclk_now;
    logic                            sclk_was;
    logic                            fs_now;
    logic                            fs_was;
    logic                            sdata_now;
    logic                            selected;
    logic                            ldn_now;
    logic                            ldn_was;
    logic                            pdn_now;
    logic                            sclk_fall;
    logic                            sclk_rise;
    logic                            fs_fall;
    logic                            fs_rise;
    logic                            latch_update_n_fall;

    // Transfer decode.
    logic [qdsi_pkg::WORD_BITS-1:0]  shift_in;
    logic                            take_bit;
    logic                            last_bit;
    logic                            early_end;
    logic                            xfer;
    logic                            late_refresh;
    logic [qdsi_pkg::WORD_BITS-1:0]  xfer_word;
    logic [qdsi_pkg::CH_BITS-1:0]    xfer_ch;
    logic [qdsi_pkg::CODE_BITS-1:0]  xfer_code;
    logic                            xfer_fast;
    logic                            xfer_pwr;
    logic [qdsi_pkg::ENTRY_BITS-1:0] xfer_entry;
    logic [qdsi_pkg::NUM_CH-1:0]     in_hit;
    logic [qdsi_pkg::NUM_CH-1:0]     out_new;
    logic [qdsi_pkg::NUM_CH-1:0]     out_copy;

    assign pins_raw = {link.sclk, link.frame_sync, link.sdata,
                       link.cs_n, link.latch_update_n,
                       link.hw_power_down_n};

    assign sclk_now  = sync2_ff[qdsi_pkg::PIN_SCLK];
    assign sclk_was  = prev_ff[qdsi_pkg::PIN_SCLK];
    assign fs_now    = sync2_ff[qdsi_pkg::PIN_FS];
    assign fs_was    = prev_ff[qdsi_pkg::PIN_FS];
    assign sdata_now = sync2_ff[qdsi_pkg::PIN_SDAT];
    assign ldn_now   = sync2_ff[qdsi_pkg::PIN_LDN];
    assign ldn_was   = prev_ff[qdsi_pkg::PIN_LDN];
    assign pdn_now   = sync2_ff[qdsi_pkg::PIN_PDN];

    // Only a selected device sees clock and frame sync edges.
    assign selected  = ~sync2_ff[qdsi_pkg::PIN_CSN];
    assign sclk_fall = selected & sclk_was & ~sclk_now;
    assign sclk_rise = selected & ~sclk_was & sclk_now;
    assign fs_fall   = selected & fs_was & ~fs_now;
    assign fs_rise   = selected & ~fs_was & fs_now;
    assign latch_update_n_fall = ldn_was & ~ldn_now;

    // A new bit enters at the bottom, so the first bit ends up on top.
    assign shift_in  = {shift_ff[qdsi_pkg::WORD_BITS-2:0],
                        sdata_now};
    assign take_bit  = active_ff & sclk_fall & ~fs_fall;
    assign last_bit  = take_bit & (cnt_ff == qdsi_pkg::LAST_BIT);
    assign early_end = active_ff & fs_rise & ~take_bit;
    assign xfer      = last_bit | early_end;
    // Frame sync rising stands in for the rising clock edge.
    assign late_refresh = pend_ff & (sclk_rise | fs_rise);

    assign xfer_word = last_bit ? shift_in : shift_ff;
    // Top four bits are control, the rest the value field.
    assign xfer_ch   = xfer_word[qdsi_pkg::ADDR_MSB_POS:
                                 qdsi_pkg::ADDR_LSB_POS];
    assign xfer_pwr  = xfer_word[qdsi_pkg::PWR_POS];
    assign xfer_fast = xfer_word[qdsi_pkg::SPD_POS];
    // The two lowest bits of the value field carry nothing.
    assign xfer_code = xfer_word[qdsi_pkg::CODE_MSB_POS:
                                 qdsi_pkg::CODE_LSB_POS];
    assign xfer_entry = {xfer_fast, xfer_code};

    for (genvar ch = 0; ch < qdsi_pkg::NUM_CH; ch++) begin : g_ch
        assign in_hit[ch]   = xfer & (xfer_ch == qdsi_pkg::CH_BITS'(ch));
        assign out_new[ch]  = early_end
                            & (xfer_ch == qdsi_pkg::CH_BITS'(ch));
        assign out_copy[ch] = latch_update_n_fall
                            | (late_refresh
                               & (pend_ch_ff == qdsi_pkg::CH_BITS'(ch)));
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_ff <= qdsi_pkg::PINS_IDLE;
            sync2_ff <= qdsi_pkg::PINS_IDLE;
            prev_ff  <= qdsi_pkg::PINS_IDLE;
        end else if (ce_in) begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Shift engine: a new frame always restarts the count.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            active_ff <= 1'b0;
            cnt_ff    <= qdsi_pkg::CNT_RST;
            shift_ff  <= qdsi_pkg::WORD_RST;
        end else if (ce_in) begin
            if (fs_fall) begin
                active_ff <= 1'b1;
                cnt_ff    <= qdsi_pkg::CNT_RST;
            end else if (take_bit) begin
                shift_ff  <= shift_in;
                cnt_ff    <= cnt_ff + 5'h01;
                active_ff <= ~last_bit;
            end else if (early_end) begin
                active_ff <= 1'b0;
            end
        end
    end

    // The rising edge after the sixteenth bit is still to come.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pend_ff    <= 1'b0;
            pend_ch_ff <= 2'h0;
        end else if (ce_in) begin
            if (last_bit) begin
                pend_ff    <= 1'b1;
                pend_ch_ff <= xfer_ch;
            end else if (late_refresh) begin
                pend_ff    <= 1'b0;
            end
        end
    end

    // An early frame end loads and shows the word at once; a latch-update
    // pulse copies every input latch out in the same cycle.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int ch = 0; ch < qdsi_pkg::NUM_CH; ch++) begin
                in_ff[ch]  <= qdsi_pkg::ENTRY_RST;
                out_ff[ch] <= qdsi_pkg::ENTRY_RST;
            end
        end else if (ce_in) begin
            for (int ch = 0; ch < qdsi_pkg::NUM_CH; ch++) begin
                if (in_hit[ch]) begin
                    in_ff[ch] <= xfer_entry;
                end
                if (out_new[ch]) begin
                    out_ff[ch] <= xfer_entry;
                end else if (out_copy[ch]) begin
                    out_ff[ch] <= in_ff[ch];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            soft_pd_ff <= 1'b0;
            amps_on_ff <= 1'b0;
            strobe_ff  <= 1'b0;
        end else if (ce_in) begin
            if (xfer) begin
                soft_pd_ff <= xfer_pwr;
            end
            amps_on_ff <= pdn_now & ~soft_pd_ff;
            strobe_ff  <= xfer;
        end
    end

    // The code drives a string DAC whose level is 2*ref*code/1024.
    for (genvar ch = 0; ch < qdsi_pkg::NUM_CH; ch++) begin : g_out
        assign dac_code_out[ch]  =
            out_ff[ch][qdsi_pkg::CODE_BITS-1:0];
        assign fast_mode_out[ch] = out_ff[ch][qdsi_pkg::CODE_BITS];
    end

    assign amps_on_out     = amps_on_ff;
    assign busy_out        = active_ff;
    assign word_strobe_out = strobe_ff;

endmodule
`default_nettype wire

// >>> hdl/qdsi_host_end.sv
/*
  Host end of the quad DAC serial link: sends one 16-bit word per request
  with its own divided link clock, pulses latch update and drives the
  hardware power-down pin.
  Assumes requests come from logic on clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none
module qdsi_host_end (
    input  wire logic                           clk_sys_in,
    input  wire logic                           nrst_in,
    input  wire logic                           ce_in,
    input  wire logic                           start_in,
    input  wire logic [qdsi_pkg::WORD_BITS-1:0] word_in,
    input  wire logic                           byte_mode_in,
    input  wire logic                           three_wire_in,
    input  wire logic                           latch_update_n_req_in,
    input  wire logic                           hw_pd_req_in,
    qdsi_link_if.host_mp                        link,
    output logic                                busy_out,
    output logic                                done_out
);

    typedef enum logic [3:0] {
        H_IDLE, H_CS_SU, H_FS_SU, H_CLK_HI, H_CLK_LO,
        H_GAP, H_TAIL_LO, H_TAIL_HI, H_FS_HOLD, H_CS_HOLD
    } qdsi_host_st_t;

    qdsi_host_st_t                  st_ff,    nxt_st;
    logic [qdsi_pkg::TMR_BITS-1:0]  tmr_ff,   nxt_tmr;
    logic [qdsi_pkg::CNT_BITS-1:0]  bits_ff,  nxt_bits;
    logic [qdsi_pkg::WORD_BITS-1:0] shift_ff, nxt_shift;
    logic                           sclk_ff,  nxt_sclk;
    logic                           fs_ff,    nxt_fs;
    logic                           sdat_ff,  nxt_sdat;
    logic                           csn_ff,   nxt_csn;
    logic                           busy_ff,  nxt_busy;
    logic                           done_ff,  nxt_done;
    logic [qdsi_pkg::TMR_BITS-1:0]  ld_tmr_ff;
    logic                           ldn_ff;
    logic                           pdn_ff;
    logic                           tick;
    logic                           msb;

    assign tick = (tmr_ff == qdsi_pkg::TMR_RST);
    assign msb  = shift_ff[qdsi_pkg::WORD_BITS-1];

    always_comb begin
        nxt_st    = st_ff;
        nxt_tmr   = tick ? qdsi_pkg::HALF_LOAD : tmr_ff - 8'h01;
        nxt_bits  = bits_ff;
        nxt_shift = shift_ff;
        nxt_sclk  = sclk_ff;
        nxt_fs    = fs_ff;
        nxt_sdat  = sdat_ff;
        nxt_csn   = csn_ff;
        nxt_busy  = busy_ff;
        nxt_done  = 1'b0;
        unique case (st_ff)
            H_IDLE: begin
                nxt_tmr = qdsi_pkg::HALF_LOAD;
                // Three-wire operation keeps the device selected.
                nxt_csn = ~three_wire_in;
                if (start_in) begin
                    nxt_csn   = 1'b0;
                    nxt_shift = word_in;
                    nxt_bits  = qdsi_pkg::CNT_RST;
                    nxt_busy  = 1'b1;
                    nxt_st    = H_CS_SU;
                end
            end
            H_CS_SU: if (tick) begin
                nxt_fs   = 1'b0;
                nxt_sdat = msb;
                nxt_st   = H_FS_SU;
            end
            H_FS_SU: if (tick) begin
                nxt_sclk = 1'b1;
                nxt_st   = H_CLK_HI;
            end
            H_CLK_HI: if (tick) begin
                nxt_sclk  = 1'b0;
                nxt_bits  = bits_ff + 5'h01;
                nxt_shift = {shift_ff[qdsi_pkg::WORD_BITS-2:0], 1'b0};
                if (bits_ff == qdsi_pkg::LAST_BIT) begin
                    nxt_st = H_TAIL_LO;
                end else if (byte_mode_in
                             && bits_ff == qdsi_pkg::BYTE_LAST) begin
                    // Second byte write follows inside the same frame.
                    nxt_tmr = qdsi_pkg::GAP_LOAD;
                    nxt_st  = H_GAP;
                end else begin
                    nxt_st = H_CLK_LO;
                end
            end
            H_CLK_LO: if (tick) begin
                nxt_sdat = msb;
                nxt_sclk = 1'b1;
                nxt_st   = H_CLK_HI;
            end
            H_GAP: if (tick) begin
                nxt_st = H_CLK_LO;
            end
            H_TAIL_LO: if (tick) begin
                nxt_sclk = 1'b1;
                nxt_st   = H_TAIL_HI;
            end
            H_TAIL_HI: if (tick) begin
                nxt_sclk = 1'b0;
                nxt_st   = H_FS_HOLD;
            end
            // Frame sync rises only after the word is complete.
            H_FS_HOLD: if (tick) begin
                nxt_fs = 1'b1;
                nxt_st = H_CS_HOLD;
            end
            H_CS_HOLD: if (tick) begin
                nxt_csn  = ~three_wire_in;
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_st   = H_IDLE;
            end
            default: nxt_st = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff    <= H_IDLE;
            tmr_ff   <= qdsi_pkg::TMR_RST;
            bits_ff  <= qdsi_pkg::CNT_RST;
            shift_ff <= qdsi_pkg::WORD_RST;
            sclk_ff  <= 1'b0;
            fs_ff    <= 1'b1;
            sdat_ff  <= 1'b0;
            csn_ff   <= 1'b1;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end else if (ce_in) begin
            st_ff    <= nxt_st;
            tmr_ff   <= nxt_tmr;
            bits_ff  <= nxt_bits;
            shift_ff <= nxt_shift;
            sclk_ff  <= nxt_sclk;
            fs_ff    <= nxt_fs;
            sdat_ff  <= nxt_sdat;
            csn_ff   <= nxt_csn;
            busy_ff  <= nxt_busy;
            done_ff  <= nxt_done;
        end
    end

    // Latch-update pulse and power-down pin, independent of the word engine.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ld_tmr_ff <= qdsi_pkg::TMR_RST;
            ldn_ff    <= 1'b1;
            pdn_ff    <= 1'b1;
        end else if (ce_in) begin
            pdn_ff <= ~hw_pd_req_in;
            if (ldn_ff && latch_update_n_req_in) begin
                ldn_ff    <= 1'b0;
                ld_tmr_ff <= qdsi_pkg::LATCH_UPDATE_N_LOAD;
            end else if (!ldn_ff) begin
                if (ld_tmr_ff == qdsi_pkg::TMR_RST) begin
                    ldn_ff <= 1'b1;
                end else begin
                    ld_tmr_ff <= ld_tmr_ff - 8'h01;
                end
            end
        end
    end

    assign link.sclk            = sclk_ff;
    assign link.frame_sync      = fs_ff;
    assign link.sdata           = sdat_ff;
    assign link.cs_n            = csn_ff;
    assign link.latch_update_n  = ldn_ff;
    assign link.hw_power_down_n = pdn_ff;
    assign busy_out             = busy_ff;
    assign done_out             = done_ff;

endmodule
`default_nettype wire

// >>> verif/qdsi_assertions.sv
/*
  Concurrent checks on the serial link between host end and DAC end.
  Assumes the link signals and the system clock and reset as inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module qdsi_assertions (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic sclk,
    input wire logic frame_sync,
    input wire logic sdata,
    input wire logic cs_n,
    input wire logic latch_update_n,
    input wire logic hw_power_down_n
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    logic [4:0] falls_ff;
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in)
            falls_ff <= 5'h00;
        else if ($fell(frame_sync))
            falls_ff <= 5'h00;
        else if ($fell(sclk))
            falls_ff <= falls_ff + 5'h01;
    end
    sequence s_clk_high;
        sclk [*8] ##1 !sclk;
    endsequence
    sequence s_ld_pulse;
        !latch_update_n [*8] ##1 latch_update_n;
    endsequence
    a_cs_before_fs: assert property (
        $fell(frame_sync) |-> !$past(cs_n))
        else $error("frame sync fell while chip select high");
    a_fs_to_clk: assert property (
        $fell(frame_sync) |-> !sclk [*8])
        else $error("link clock rose too soon after frame sync");
    a_data_stable: assert property ($fell(sclk) |-> $stable(sdata))
        else $error("data moved at link clock fall");
    a_clk_half: assert property ($rose(sclk) |-> s_clk_high)
        else $error("link clock high phase wrong");
    a_clk_idle: assert property (frame_sync |-> !sclk)
        else $error("link clock high outside frame");
    // Sixteen data falls plus the fall after the refresh edge.
    a_word_bits: assert property (
        $rose(frame_sync) |-> falls_ff == 5'h11)
        else $error("frame did not carry sixteen bits");
    a_fs_before_cs: assert property (
        $rose(cs_n) |-> $past(frame_sync))
        else $error("chip select rose inside frame");
    a_ld_pulse: assert property (
        $fell(latch_update_n) |-> s_ld_pulse)
        else $error("latch update pulse width wrong");
endmodule
`default_nettype wire

// >>> verif/quad_dac_serial_interface_tb.sv
/*
  Self-checking bench: host end and DAC end joined by one link, plus a
  second DAC end driven directly by the bench to break framing rules.
  Assumes a 100 MHz system clock and the design's 8-cycle half period.
*/
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_interface_tb;
    logic clk = 1'b0, nrst = 1'b0, start = 1'b0, bm = 1'b0, tw = 1'b0;
    logic ld = 1'b0, pd = 1'b0, done, strb;
    logic [15:0] word = 16'h0000;
    logic [3:0][9:0] code, code2, keep;
    logic [3:0] fast;
    logic amps, hb, db;
    int err_count = 0, comparisons = 0, words = 0, strobes = 0;
    qdsi_link_if link ();
    qdsi_link_if link2 ();
    qdsi_host_end u_qdsi_host_end (.clk_sys_in(clk), .nrst_in(nrst),
        .ce_in(1'b1), .start_in(start), .word_in(word), .byte_mode_in(bm),
        .three_wire_in(tw), .latch_update_n_req_in(ld), .hw_pd_req_in(pd),
        .link(link), .busy_out(hb), .done_out(done));
    qdsi_dac_end u_qdsi_dac_end (.clk_sys_in(clk), .nrst_in(nrst),
        .ce_in(1'b1), .link(link), .dac_code_out(code),
        .fast_mode_out(fast), .amps_on_out(amps), .busy_out(db),
        .word_strobe_out(strb));
    qdsi_dac_end u_qdsi_dac_end2 (.clk_sys_in(clk), .nrst_in(nrst),
        .ce_in(1'b1), .link(link2), .dac_code_out(code2),
        .fast_mode_out(), .amps_on_out(), .busy_out(),
        .word_strobe_out());
    qdsi_assertions u_qdsi_assertions (.clk_sys_in(clk), .nrst_in(nrst),
        .sclk(link.sclk), .frame_sync(link.frame_sync), .sdata(link.sdata),
        .cs_n(link.cs_n), .latch_update_n(link.latch_update_n),
        .hw_power_down_n(link.hw_power_down_n));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (strb === 1'b1) strobes++;
    function automatic logic [15:0] code_of(input logic [15:0] w);
        return {6'h00, w[11:2]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic send(input logic [15:0] w);
        int k;
        word <= w;
        bm <= 1'($urandom);
        tw <= 1'($urandom);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (k = 0; k < 1000; k++) begin
            @(posedge clk);
            if (k == 0) chk({15'h0000, hb}, 16'h0001);
            if (done === 1'b1) break;
        end
        chk(16'(k < 1000), 16'h0001);
        words++;
        repeat (4) @(posedge clk);
        chk({6'h00, code[w[15:14]]}, code_of(w));
        chk({15'h0000, fast[w[15:14]]}, {15'h0000, w[12]});
        chk({15'h0000, amps}, {15'h0000, ~w[13]});
        chk({15'h0000, db}, 16'h0000);
    endtask
    // Bench-made frame on the second link; n below 16 ends it early.
    task automatic bang(input logic [15:0] w, input int n, input logic c);
        link2.cs_n <= c;
        repeat (8) @(posedge clk);
        link2.frame_sync <= 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (8) @(posedge clk);
            link2.sdata <= w[15-i];
            link2.sclk <= 1'b1;
            repeat (8) @(posedge clk);
            link2.sclk <= 1'b0;
        end
        repeat (8) @(posedge clk);
        // A full word deselects first, so no edge refreshes its output.
        if (n == 16) link2.cs_n <= 1'b1;
        repeat (8) @(posedge clk);
        link2.frame_sync <= 1'b1;
        link2.sdata <= ~link2.sdata;
        repeat (8) @(posedge clk);
        link2.cs_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        end_of_test();
    end
    initial begin
        logic [15:0] w;
        {link2.sclk, link2.sdata, link2.latch_update_n} = 3'h1;
        {link2.frame_sync, link2.cs_n, link2.hw_power_down_n} = 3'h7;
        void'($urandom(32'h814F));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        chk({15'h0000, |code}, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            w = 16'($urandom) & 16'hDFFF;
            w[15:12] = {i[1:0], 1'b0, i[2]};
            if (i == 8) w[11:2] = 10'h3FF;
            if (i == 9) w[11:2] = 10'h000;
            send(w);
        end
        send(16'h6FFC);
        send(16'h1804);
        chk(16'(strobes), 16'(words));
        keep = code;
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        repeat (20) @(posedge clk);
        chk({15'h0000, |(code ^ keep)}, 16'h0000);
        pd <= 1'b1;
        repeat (8) @(posedge clk);
        chk({15'h0000, amps}, 16'h0000);
        pd <= 1'b0;
        repeat (8) @(posedge clk);
        chk({15'h0000, amps}, 16'h0001);
        bang(16'hC8A5, 16, 1'b1);
        chk({15'h0000, |code2}, 16'h0000);
        bang(16'h5A5C, 12, 1'b0);
        w = 16'h05A5;
        chk({6'h00, code2[0]}, code_of(w));
        // A full word with no refresh edge waits in its input latch.
        bang(16'h8FFC, 16, 1'b0);
        chk({6'h00, code2[2]}, 16'h0000);
        link2.latch_update_n <= 1'b0;
        repeat (8) @(posedge clk);
        link2.latch_update_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk({6'h00, code2[2]}, code_of(16'h8FFC));
        end_of_test();
    end
endmodule
`default_nettype wire
